// ### hdl/adc_host_pkg.sv
// Purpose: Shared constants and types for the half-flash converter host.
// Assumes: pclk at 100 MHz; software reaches the host over APB.
// Notes: Register offsets are byte addresses of aligned 32-bit words.
package adc_host_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // Wake wait after power-down release, in ns and in cycles (rounded up).
  localparam int WAKE_NS = 900;
  localparam int WAKE_CYCLES = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Least read strobe width in write-read mode, used as a read hold.
  localparam int READ_NS = 400;
  localparam int READ_CYCLES = (READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Least write strobe width.
  localparam int WRITE_NS = 600;
  localparam int WRITE_CYCLES =
    (WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] WAKE_CNT = CNT_W'(WAKE_CYCLES);
  localparam logic [CNT_W-1:0] READ_CNT = CNT_W'(READ_CYCLES);
  localparam logic [CNT_W-1:0] WRITE_CNT = CNT_W'(WRITE_CYCLES);
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

  // Register offsets.
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] START_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam logic [7:0] RESULT_OFFSET = 8'h0c;

  // Control register fields.
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_AWAKE_BIT = 1;
  localparam int CTRL_CHAN_LSB = 4;
  localparam int CHAN_W = 3;
  // Status register fields.
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_WAKING_BIT = 2;
  localparam int STAT_READY_BIT = 3;
  localparam int STAT_DONE_N_BIT = 4;

  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic [2:0] {
    st_idle,
    st_wake,
    st_write,
    st_wait_done,
    st_read,
    st_finish
  } host_state_t;
endpackage

// ### hdl/adc_cmd_if.sv
// Purpose: Carries commands and results between the APB front end and
// the pin sequencer.
// Assumes: One clock domain.
// Notes: The front end issues start pulses; the sequencer reports back.
`timescale 1ns/100ps
interface adc_cmd_if;
  logic start;
  logic write_read_mode;
  logic awake;
  logic [adc_host_pkg::CHAN_W-1:0] channel;
  logic busy;
  logic waking;
  logic done;
  logic [7:0] result;
  modport front (output start, output write_read_mode, output awake,
    output channel, input busy, input waking, input done, input result);
  modport seq (input start, input write_read_mode, input awake,
    input channel, output busy, output waking, output done, output result);
endinterface

// ### hdl/adc_pin_seq.sv
// Purpose: Drives the converter pins through one conversion per start taken while awake and idle.
// Assumes: Converter outputs are synchronous to pclk.
// Notes: Waits for the done flag; no time limit is imposed.
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/100ps
module adc_pin_seq (
  input wire logic pclk,
  input wire logic presetn,
  adc_cmd_if.seq cmd,
  output logic chip_select_n,
  output logic read_strobe_n,
  output logic wr_out,
  output logic wr_oe,
  input wire logic ready_in,
  input wire logic conversion_done_n,
  input wire logic [7:0] result_in,
  output logic power_down_n,
  output logic mode,
  output logic [2:0] channel_address
);
  typedef struct packed {
    adc_host_pkg::host_state_t st;
    logic [adc_host_pkg::CNT_W-1:0] cnt;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic pd_n;
    logic md;
    logic [2:0] addr;
    logic done;
    logic [7:0] result;
  } seq_state_t;
  seq_state_t r;
  seq_state_t next_r;

  // Pin outputs come straight from flip-flops.
  assign chip_select_n = r.cs_n;
  assign read_strobe_n = r.rd_n;
  assign wr_out = r.wr_n;
  assign wr_oe = r.md; // The write pin is an input of the device only then.
  assign power_down_n = r.pd_n;
  assign mode = r.md;
  assign channel_address = r.addr;
  assign cmd.busy = (r.st != adc_host_pkg::st_idle);
  assign cmd.waking = (r.st == adc_host_pkg::st_wake);
  assign cmd.done = r.done;
  assign cmd.result = r.result;

  // Next-state logic of the pin sequence.
  always_comb begin
    next_r = r;
    next_r.pd_n = cmd.awake;
    if (r.cnt != adc_host_pkg::CNT_ZERO) begin
      next_r.cnt = r.cnt - adc_host_pkg::CNT_ONE;
    end
    case (r.st)
      adc_host_pkg::st_idle: begin
        if (!cmd.awake) begin
          next_r.cnt = adc_host_pkg::WAKE_CNT;
        end
        if (cmd.start && cmd.awake) begin
          next_r.done = 1'b0;
          next_r.md = cmd.write_read_mode;
          next_r.addr = cmd.channel;
          next_r.st = adc_host_pkg::st_wake;
        end
      end
      adc_host_pkg::st_wake: begin
        // Hold off until the wake time is over.
        if (r.cnt == adc_host_pkg::CNT_ZERO) begin
          next_r.cs_n = 1'b0;
          if (r.md) begin
            next_r.wr_n = 1'b0;
            next_r.cnt = adc_host_pkg::WRITE_CNT;
            next_r.st = adc_host_pkg::st_write;
          end else begin
            next_r.rd_n = 1'b0;
            next_r.st = adc_host_pkg::st_wait_done;
          end
        end
      end
      adc_host_pkg::st_write: begin
        if (r.cnt == adc_host_pkg::CNT_ZERO) begin
          next_r.wr_n = 1'b1;
          next_r.st = adc_host_pkg::st_wait_done;
        end
      end
      adc_host_pkg::st_wait_done: begin
        // The device signals the end by pulling its done line low.
        if (!conversion_done_n && (r.md || ready_in)) begin
          if (r.md) begin
            next_r.rd_n = 1'b0;
            next_r.cnt = adc_host_pkg::READ_CNT;
            next_r.st = adc_host_pkg::st_read;
          end else begin
            next_r.result = result_in;
            next_r.st = adc_host_pkg::st_finish;
          end
        end
      end
      adc_host_pkg::st_read: begin
        if (r.cnt == adc_host_pkg::CNT_ZERO) begin
          next_r.result = result_in;
          next_r.st = adc_host_pkg::st_finish;
        end
      end
      adc_host_pkg::st_finish: begin
        // Strobe release clears the done flag in the device.
        next_r.rd_n = 1'b1;
        next_r.cs_n = 1'b1;
        next_r.done = 1'b1;
        next_r.cnt = adc_host_pkg::CNT_ZERO;
        next_r.st = adc_host_pkg::st_idle;
      end
      default: begin
        next_r.st = adc_host_pkg::st_idle;
      end
    endcase
    if (!cmd.awake) begin
      // Power-down aborts any pending conversion.
      next_r.cs_n = 1'b1;
      next_r.rd_n = 1'b1;
      next_r.wr_n = 1'b1;
      next_r.st = adc_host_pkg::st_idle;
      next_r.cnt = adc_host_pkg::WAKE_CNT;
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{st: adc_host_pkg::st_idle, cnt: adc_host_pkg::WAKE_CNT,
        cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, pd_n: 1'b0, md: 1'b0,
        addr: 3'h0, done: 1'b0, result: adc_host_pkg::BYTE_ZERO};
    end else begin
      r <= next_r;
    end
  end
endmodule

// ### hdl/adc_host.sv
// Purpose: APB-controlled host that runs a half-flash converter by pins.
// Assumes: Converter outputs are synchronous to pclk; zero-wait APB.
// Notes: One conversion per write to the start register while awake and idle; other start writes are ignored.
`timescale 1ns/100ps
// Notes on behaviour
// - Hold read strobe low while sampling data.
// - Chip select low around every strobe.
// - Channel address binary, top line most significant.
// - Wait 900 ns after wake before converting.
// - Read mode: chip select and read start.
// - Write-read: write falls starts, rise latches upper.
module adc_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic chip_select_n,
  output logic read_strobe_n,
  output logic write_strobe_out,
  output logic write_strobe_oe,
  input wire logic write_strobe_ready_in,
  input wire logic conversion_done_n,
  input wire logic [7:0] result_in,
  output logic power_down_n,
  output logic mode,
  output logic [2:0] channel_address
);
  typedef struct packed {
    logic md;
    logic awake;
    logic [2:0] chan;
    logic start;
    logic [31:0] rdata;
  } front_state_t;
  front_state_t f;
  front_state_t next_f;
  adc_cmd_if cmd ();
  logic access;

  // Decides whether an offset is one of the mapped registers.
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == adc_host_pkg::CTRL_OFFSET) ||
      (a == adc_host_pkg::START_OFFSET) ||
      (a == adc_host_pkg::STATUS_OFFSET) ||
      (a == adc_host_pkg::RESULT_OFFSET);
  endfunction

  // Zero-wait slave: every access completes in its first access cycle.
  assign access = psel && penable;
  assign pready = 1'b1;
  assign pslverr = access && !mapped(paddr);
  assign prdata = f.rdata;
  assign cmd.start = f.start;
  assign cmd.write_read_mode = f.md;
  assign cmd.awake = f.awake;
  assign cmd.channel = f.chan;

  // Register writes, start pulse and read data capture.
  always_comb begin
    next_f = f;
    next_f.start = 1'b0;
    next_f.rdata = adc_host_pkg::WORD_ZERO;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        adc_host_pkg::CTRL_OFFSET: begin
          next_f.rdata[adc_host_pkg::CTRL_MODE_BIT] = f.md;
          next_f.rdata[adc_host_pkg::CTRL_AWAKE_BIT] = f.awake;
          next_f.rdata[adc_host_pkg::CTRL_CHAN_LSB +: 3] = f.chan;
        end
        adc_host_pkg::STATUS_OFFSET: begin
          next_f.rdata[adc_host_pkg::STAT_BUSY_BIT] = cmd.busy;
          next_f.rdata[adc_host_pkg::STAT_DONE_BIT] = cmd.done;
          next_f.rdata[adc_host_pkg::STAT_WAKING_BIT] = cmd.waking;
          // Ready status pin is only meaningful in read mode.
          next_f.rdata[adc_host_pkg::STAT_READY_BIT] =
            !f.md && write_strobe_ready_in;
          next_f.rdata[adc_host_pkg::STAT_DONE_N_BIT] = conversion_done_n;
        end
        adc_host_pkg::RESULT_OFFSET: begin
          // Upper and lower nibbles arrive as one byte.
          next_f.rdata[7:0] = cmd.result;
        end
        default: begin
          next_f.rdata = adc_host_pkg::WORD_ZERO;
        end
      endcase
    end else if (psel && !penable) begin
      next_f.rdata = adc_host_pkg::WORD_ZERO;
    end else if (access && !pwrite) begin
      next_f.rdata = f.rdata;
    end
    if (access && pwrite) begin
      if (paddr == adc_host_pkg::CTRL_OFFSET) begin
        next_f.md = pwdata[adc_host_pkg::CTRL_MODE_BIT];
        next_f.awake = pwdata[adc_host_pkg::CTRL_AWAKE_BIT];
        // Value 7 on eight inputs reads the reference.
        next_f.chan = pwdata[adc_host_pkg::CTRL_CHAN_LSB +: 3];
      end
      if (paddr == adc_host_pkg::START_OFFSET) begin
        next_f.start = 1'b1;
      end
    end
  end

  // Front-end register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      f <= '{md: 1'b0, awake: 1'b0, chan: 3'h0, start: 1'b0,
        rdata: adc_host_pkg::WORD_ZERO};
    end else begin
      f <= next_f;
    end
  end

  // Pin sequencer.
  adc_pin_seq seq_inst (
    .pclk(pclk),
    .presetn(presetn),
    .cmd(cmd.seq),
    .chip_select_n(chip_select_n),
    .read_strobe_n(read_strobe_n),
    .wr_out(write_strobe_out),
    .wr_oe(write_strobe_oe),
    .ready_in(write_strobe_ready_in),
    .conversion_done_n(conversion_done_n),
    .result_in(result_in),
    .power_down_n(power_down_n),
    .mode(mode),
    .channel_address(channel_address)
  );
endmodule

// ### verif/adc_host_monitor.sv
// Purpose: Checks pin sequencing of the converter host.
// Assumes: One clock; only the host's ports are seen.
// Notes: Helper counters measure awake time and strobe widths.
`timescale 1ns/100ps
module adc_host_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_out,
  input wire logic write_strobe_oe,
  input wire logic write_strobe_ready_in,
  input wire logic conversion_done_n,
  input wire logic power_down_n,
  input wire logic mode
);
  localparam logic [7:0] WAKE_MIN = 8'(adc_host_pkg::WAKE_CYCLES - 1);
  logic [7:0] up_cnt;
  logic [7:0] wr_cnt;
  logic [7:0] rd_cnt;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Saturating counts of awake cycles and of low strobe cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_cnt <= 8'h00;
      wr_cnt <= 8'h00;
      rd_cnt <= 8'h00;
    end else begin
      up_cnt <= !power_down_n ? 8'h00 : up_cnt + 8'(up_cnt != 8'hff);
      wr_cnt <= write_strobe_out ? 8'h00 : wr_cnt + 8'(wr_cnt != 8'hff);
      rd_cnt <= read_strobe_n ? 8'h00 : rd_cnt + 8'(rd_cnt != 8'hff);
    end
  end
  // A finished read-mode conversion is followed by strobe release.
  sequence s_done_seen;
    !chip_select_n && !read_strobe_n && !mode && !conversion_done_n
      && write_strobe_ready_in;
  endsequence
  sequence s_release;
    ##[1:3] (chip_select_n && read_strobe_n);
  endsequence
  property p_release; s_done_seen |-> s_release; endproperty
  a_release: assert property (p_release) else $error("no release");
  property p_cs_rd; !read_strobe_n |-> !chip_select_n; endproperty
  a_cs_rd: assert property (p_cs_rd) else $error("rd without cs");
  property p_oe_mode; !chip_select_n |-> write_strobe_oe == mode; endproperty
  a_oe_mode: assert property (p_oe_mode) else $error("oe vs mode");
  property p_asleep; !power_down_n [*3] |-> chip_select_n; endproperty
  a_asleep: assert property (p_asleep) else $error("cs asleep");
  property p_wake; $fell(chip_select_n) |-> up_cnt >= WAKE_MIN; endproperty
  a_wake: assert property (p_wake) else $error("wake too short");
  property p_wr_width;
    $rose(write_strobe_out) && write_strobe_oe
      |-> wr_cnt >= adc_host_pkg::WRITE_CNT;
  endproperty
  a_wr_width: assert property (p_wr_width) else $error("wr short");
  property p_rd_hold;
    mode && $rose(read_strobe_n) |-> rd_cnt >= adc_host_pkg::READ_CNT;
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("rd short");
  property p_rd_late; mode && $fell(read_strobe_n) |-> !conversion_done_n;
  endproperty
  a_rd_late: assert property (p_rd_late) else $error("rd early");
endmodule
bind adc_host adc_host_monitor u_mon (.pclk(pclk), .presetn(presetn),
  .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
  .write_strobe_out(write_strobe_out), .write_strobe_oe(write_strobe_oe),
  .write_strobe_ready_in(write_strobe_ready_in),
  .conversion_done_n(conversion_done_n), .power_down_n(power_down_n),
  .mode(mode));

// ### verif/adc_dev_model.sv
// Purpose: Behavioural half-flash converter seen from its pins.
// Assumes: Pins are sampled on pclk.
// Notes: An idle result bus shows the inverse of the last value.
`timescale 1ns/100ps
module adc_dev_model (
  input wire logic pclk,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_pin,
  input wire logic power_down_n,
  input wire logic mode,
  input wire logic [2:0] channel_address,
  input wire logic [55:0] analog_in,
  output logic ready,
  output logic conversion_done_n,
  output logic [7:0] result_out
);
  logic [7:0] latch, sample;
  logic [4:0] cnt;
  logic busy, cs_q, rd_q, wr_q, wrd, start;
  // An undriven mode pin reads as read mode.
  assign wrd = (mode === 1'b1);
  // Address n picks input n+1; the eighth reads the upper reference.
  assign sample = (channel_address == 3'h7) ? 8'hff
    : analog_in[8*channel_address +: 8];
  assign result_out = (!chip_select_n && !read_strobe_n) ? latch
    : ~latch;
  assign ready = !(busy && !wrd);
  assign start = !busy && conversion_done_n && !chip_select_n && (wrd
    ? (!write_pin && wr_q) : (!read_strobe_n && (rd_q || cs_q)));
  initial begin
    {busy, cs_q, rd_q, wr_q, conversion_done_n} = 5'h0f;
    latch = 8'h00;
    cnt = 5'h00;
  end
  // Two nibble steps per conversion; power-down stops all work.
  always @(posedge pclk) begin
    cs_q <= chip_select_n;
    rd_q <= read_strobe_n;
    wr_q <= write_pin;
    if (!power_down_n) begin
      busy <= 1'b0;
      conversion_done_n <= 1'b1;
    end else if (start) begin
      busy <= 1'b1;
      cnt <= 5'h10;
    end else if (busy && !(wrd && !write_pin)) begin
      cnt <= cnt - 5'h01;
      if (wrd ? !wr_q : cnt == 5'h08)
        latch[7:4] <= sample[7:4];
      if (cnt == 5'h01) begin
        latch[3:0] <= sample[3:0];
        conversion_done_n <= 1'b0;
        busy <= 1'b0;
      end
    end
    if ((chip_select_n && !cs_q) || (read_strobe_n && !rd_q))
      conversion_done_n <= 1'b1;
  end
endmodule

// ### verif/adc_host_tb.sv
// Purpose: Runs the converter host over APB against a device model.
// Assumes: pclk at 100 MHz.
// Notes: Levels come from a fixed-seed xorshift, as do modes and channels of the sweep after its first eight conversions.
`timescale 1ns/100ps
module adc_host_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic cs_n, rd_n, wr_out, wr_oe, rdy, wr_wire, done_n, pd_n, mode;
  logic [7:0] paddr, dev_data;
  logic [2:0] chan;
  logic [31:0] pwdata, prdata, rdata, seed;
  logic [55:0] levels;
  int fail_count, samples_checked;
  // The shared pin carries the host's strobe or the device's status.
  assign wr_wire = wr_oe ? wr_out : rdy;
  adc_host u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_select_n(cs_n), .read_strobe_n(rd_n),
    .write_strobe_out(wr_out), .write_strobe_oe(wr_oe),
    .write_strobe_ready_in(wr_wire), .conversion_done_n(done_n),
    .result_in(dev_data), .power_down_n(pd_n), .mode(mode),
    .channel_address(chan));
  adc_dev_model u_dev (.pclk(pclk), .chip_select_n(cs_n),
    .read_strobe_n(rd_n), .write_pin(wr_wire), .power_down_n(pd_n),
    .mode(mode), .channel_address(chan), .analog_in(levels),
    .ready(rdy), .conversion_done_n(done_n), .result_out(dev_data));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [7:0] expect_val(input logic [2:0] c);
    return (c == 3'h7) ? 8'hff : levels[8*c +: 8];
  endfunction
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdata = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    if (n >= 50) begin
      fail_count++;
      print_verdict();
    end
  endtask
  task automatic wait_for(ref logic s, input logic v, input int lim);
    int n;
    for (n = 0; s !== v && n < lim; n++) @(posedge pclk);
    if (n >= lim) begin
      fail_count++;
      print_verdict();
    end
  endtask
  task automatic convert(input logic m, input logic [2:0] c);
    int n;
    seed = xs(seed);
    if (c != 3'h7) levels[8*c +: 8] <= seed[7:0];
    apb(1'b1, adc_host_pkg::CTRL_OFFSET, {25'h0, c, 3'b001, m});
    apb(1'b1, adc_host_pkg::START_OFFSET, 32'h1);
    apb(1'b0, adc_host_pkg::STATUS_OFFSET, 32'h0);
    check("waking", {29'h0, rdata[2:0]}, 32'h5);
    wait_for(cs_n, 1'b0, 300);
    n = 0;
    do begin
      apb(1'b0, adc_host_pkg::STATUS_OFFSET, 32'h0);
      n++;
    end while (rdata[adc_host_pkg::STAT_DONE_BIT] !== 1'b1 && n < 300);
    if (n >= 300) begin
      fail_count++;
      print_verdict();
    end
    check("status done", {30'h0, rdata[1:0]}, 32'h2);
    apb(1'b0, adc_host_pkg::RESULT_OFFSET, 32'h0);
    check("result", rdata, {24'h0, expect_val(c)});
    check("mode pin", {31'h0, mode}, {31'h0, m});
    check("address", {29'h0, chan}, {29'h0, c});
  endtask
  // Reset, refusals, a sweep of channels and modes, an abort, then one more conversion.
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 44'h0;
    {levels, fail_count, samples_checked, seed} = {56'h0, 64'h0, 32'h51af};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    check("pd reset", {31'h0, pd_n}, 32'h0);
    apb(1'b0, adc_host_pkg::CTRL_OFFSET, 32'h0);
    check("ctrl reset", rdata, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped", {31'h0, err}, 32'h1);
    apb(1'b1, adc_host_pkg::START_OFFSET, 32'h1);
    repeat (adc_host_pkg::WAKE_CYCLES + 10) @(posedge pclk);
    check("cs asleep", {31'h0, cs_n}, 32'h1);
    for (int i = 0; i < 14; i++) begin
      seed = xs(seed);
      convert(i < 8 ? i[0] : seed[8], i < 8 ? 3'(i) : seed[2:0]);
    end
    apb(1'b1, adc_host_pkg::CTRL_OFFSET, 32'h12);
    apb(1'b1, adc_host_pkg::START_OFFSET, 32'h1);
    wait_for(cs_n, 1'b0, 300);
    apb(1'b1, adc_host_pkg::CTRL_OFFSET, 32'h10);
    wait_for(pd_n, 1'b0, 10);
    @(posedge pclk);
    check("abort", {30'h0, cs_n, rd_n}, 32'h3);
    convert(1'b0, 3'h1);
    print_verdict();
  end
endmodule
